/* File: design/clock_synth_control_select_map.sv */
// Configuration register map and control-pin setting selection.
// Assumes sda/scl open-drain pins with pull-ups, and a strap that says
// whether the dual-function pins act as bus or as control pins.
//
// Functional notes
// [R1] Byte zero holds identity; read only here.
// [R2] Master should not overwrite byte zero.
// [R3] Master keeps serial clock at 400 kHz.
// [R4] Offsets decode into five configuration groups.
// [R5] Eight control setting sets are held.
// [R6] Control pins form a binary set index.
// [R7] Set: output, frequency, spread, pair fields.
// [R8] Output 04h; first PLL at 10h-15h.
// [R9] Other PLLs at 20h, 30h, 40h.
// [R10] All settings writable over the serial bus.
// [R11] Command bit 7 picks byte mode; offset.
// [R12] Bus pins count as zero in index.
`timescale 1ns/10ps
module clock_synth_control_select_map
   import clk_synth_cfg_pkg::*;
#(
   // Arbitrary neutral identity byte.
   parameter logic [7:0] ID_BYTE = 8'h5A,
   // Arbitrary upper bits of the bus address; the low two come from byte 01h.
   parameter logic [4:0] BUS_ADDR_HI = 5'h19
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic pins_as_control,
   input wire logic ctl_pin_lsb,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output set_fields_t fields
);

   // ==========================================================================
   // Pin conditioning
   // ==========================================================================
   logic lsb_f;
   logic scl_f;
   logic sda_f;
   logic scl_prev;
   logic sda_prev;

   pin_sync #(.WIDTH(3), .RESET_LEVEL(3'b110)) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .pin({scl_in, sda_in, ctl_pin_lsb}),
      .level({scl_f, sda_f, lsb_f})
   );

   always_ff @(posedge core_clk) begin
      if (srst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end

   // Bus events are ignored entirely while the pins serve as control inputs.
   wire bus_on = ~pins_as_control;
   wire start_ev = bus_on & scl_f & scl_prev & sda_prev & ~sda_f;
   wire stop_ev = bus_on & scl_f & scl_prev & ~sda_prev & sda_f;
   wire rise_ev = bus_on & scl_f & ~scl_prev;
   wire fall_ev = bus_on & ~scl_f & scl_prev;

   // ==========================================================================
   // Register storage
   // ==========================================================================
   logic [7:0] regs [0:REG_COUNT-1];

   function automatic logic [7:0] reset_value(input int idx);
      logic [6:0] off;
      off = 7'(idx);
      // Output selects enable the outputs in set 1 and park them in set 0.
      if (off == SINGLE_OUT_OFFSET || (off[6:4] != 3'h0 && off[3:0] == PAIR_REL_OFFSET[3:0])) begin
         return OUT_SELECT_RESET;
      end
      return PLAIN_RESET;
   endfunction

   // Read decode: byte zero returns identity, unmapped offsets read zero.
   // The stored byte comes in as an argument so that the read path follows
   // register writes; a body that read the array itself would hide it from
   // the continuous assignment that calls this function.
   function automatic logic [7:0] read_byte(input logic [6:0] off, input logic [7:0] stored);
      if (off == ID_BYTE_OFFSET) begin
         return ID_BYTE; // [R1]
      end
      if (int'(off) >= REG_COUNT) begin
         return 8'h00;
      end
      return stored; // [R4]
   endfunction

   // ==========================================================================
   // Serial slave state
   // ==========================================================================
   typedef enum logic [3:0] {
      st_idle, st_addr, st_addr_ack, st_cmd, st_cmd_ack,
      st_wr, st_wr_ack, st_rd, st_rd_ack
   } bus_state_t;

   bus_state_t state;
   bus_state_t next_state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [6:0] ptr;
   logic byte_mode;
   logic byte_used;
   logic [7:0] next_shreg;

   wire byte_done = (bit_cnt == 4'd8);
   wire [6:0] my_addr = {BUS_ADDR_HI, regs[DEV_ADDR_OFFSET][DEV_ADDR_MSB:DEV_ADDR_LSB]};
   wire addr_hit = (shreg[7:1] == my_addr);
   wire is_read = shreg[0];
   // Only one data byte is taken in byte mode; block mode streams on.
   wire data_ok = ~(byte_mode & byte_used);
   // Identity byte and unmapped offsets are protected from writes.
   wire wr_legal = (ptr != ID_BYTE_OFFSET) && (int'(ptr) < REG_COUNT); // [R1] [R2]
   wire do_write = (state == st_wr) & fall_ev & byte_done & data_ok & wr_legal; // [R10]
   wire [7:0] rd_now = read_byte(ptr, regs[ptr]);
   wire [6:0] ptr_inc = ptr + 7'd1;

   // Next state on SCL falls, where the slave may change SDA.
   always_comb begin
      next_state = state;
      unique case (state)
         st_idle: next_state = st_idle;
         st_addr: begin
            if (byte_done) begin
               next_state = addr_hit ? st_addr_ack : st_idle;
            end
         end
         st_addr_ack: next_state = is_read ? st_rd : st_cmd;
         st_cmd: begin
            if (byte_done) begin
               next_state = st_cmd_ack;
            end
         end
         st_cmd_ack: next_state = st_wr;
         st_wr: begin
            if (byte_done) begin
               next_state = data_ok ? st_wr_ack : st_idle;
            end
         end
         st_wr_ack: next_state = st_wr;
         st_rd: begin
            if (byte_done) begin
               next_state = st_rd_ack;
            end
         end
         st_rd_ack: next_state = st_rd;
      endcase
   end

   // Shift register: receive on rise, or shift out the next read bit on fall.
   assign next_shreg = (state == st_rd) ? {shreg[6:0], 1'b0} : shreg;

   // Bus control sequencing; start and stop win over any bit activity.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= st_idle;
         bit_cnt <= 4'd0;
         shreg <= 8'h00;
         ptr <= 7'h00;
         byte_mode <= 1'b0;
         byte_used <= 1'b0;
         sda_oe <= 1'b0;
      end else if (pins_as_control || stop_ev) begin
         state <= st_idle;
         sda_oe <= 1'b0;
      end else if (start_ev) begin
         state <= st_addr;
         bit_cnt <= 4'd0;
         sda_oe <= 1'b0;
      end else if (rise_ev) begin
         if (state == st_rd_ack) begin
            // A master NACK ends the read; the bus waits for stop or restart.
            if (sda_f) begin
               state <= st_idle;
            end
         end else if (state != st_idle && !byte_done) begin
            if (state != st_rd) begin
               shreg <= {shreg[6:0], sda_f};
            end
            bit_cnt <= bit_cnt + 4'd1;
         end
      end else if (fall_ev && state != st_idle) begin
         state <= next_state;
         unique case (state)
            st_cmd: begin
               if (byte_done) begin
                  byte_mode <= shreg[CMD_BYTE_MODE_BIT]; // [R11]
                  ptr <= shreg[6:0]; // [R11]
                  byte_used <= 1'b0;
               end
            end
            st_wr: begin
               if (byte_done && data_ok) begin
                  byte_used <= 1'b1;
                  if (!byte_mode) begin
                     ptr <= ptr_inc;
                  end
               end
            end
            st_rd: begin
               if (byte_done && !byte_mode) begin
                  ptr <= ptr_inc;
               end
            end
            default: begin
            end
         endcase
         // Drive ack, load read data or release SDA for the coming bit.
         if (next_state == st_addr_ack || next_state == st_cmd_ack
             || next_state == st_wr_ack) begin
            sda_oe <= 1'b1;
         end else if (state == st_addr_ack && is_read) begin
            // The count starts at zero so all eight rises pass before the ack slot.
            shreg <= {rd_now[6:0], 1'b0};
            sda_oe <= ~rd_now[7];
            bit_cnt <= 4'd0;
         end else if (state == st_rd_ack) begin
            shreg <= {rd_now[6:0], 1'b0};
            sda_oe <= ~rd_now[7];
            bit_cnt <= 4'd0;
         end else if (state == st_rd && !byte_done) begin
            shreg <= next_shreg;
            sda_oe <= ~shreg[7];
         end else begin
            sda_oe <= 1'b0;
            if (state == st_addr_ack || state == st_cmd_ack || state == st_wr_ack) begin
               bit_cnt <= 4'd0;
            end
         end
      end
   end

   // Open-drain data pin: the slave only ever pulls low.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Register writes take effect at once; the loop restores factory values.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= reset_value(i);
         end
      end else if (do_write) begin
         regs[ptr] <= shreg; // [R10]
      end
   end

   // ==========================================================================
   // Setting-set selection
   // ==========================================================================
   logic [2:0] set_index;
   logic [3:0] freq_sel;
   logic [3:0] pair_sel;
   logic [3:0][2:0] spread_sel;
   set_fields_t next_fields;

   // While the dual pins carry the bus they read as zero in the index.
   assign set_index = pins_as_control ? {scl_f, sda_f, lsb_f} : {2'b00, lsb_f}; // [R6] [R12]

   // One bit per set in each select byte, so eight sets share a byte.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pll
         localparam logic [6:0] BASE = FIRST_PLL_CONFIGURATION_GROUP + 7'(16 * g); // [R4] [R9]
         assign freq_sel[g] = regs[BASE + FREQ_REL_OFFSET][set_index]; // [R7] [R8]
         assign pair_sel[g] = regs[BASE + PAIR_REL_OFFSET][set_index]; // [R8]
         for (genvar b = 0; b < SPREAD_BYTES; b++) begin : g_spread
            assign spread_sel[g][b] = regs[BASE + SPREAD_REL_OFFSET + 7'(b)][set_index];
         end
      end
   endgenerate

   // Gather the active set; all eight stay stored and any can be picked.
   always_comb begin
      next_fields.active_set = set_index; // [R5]
      next_fields.single_output_select = regs[SINGLE_OUT_OFFSET][set_index]; // [R8]
      next_fields.pll_a_freq_select = freq_sel[0];
      next_fields.pll_b_freq_select = freq_sel[1];
      next_fields.pll_c_freq_select = freq_sel[2];
      next_fields.pll_d_freq_select = freq_sel[3];
      next_fields.pll_a_spread_select = spread_sel[0];
      next_fields.pll_b_spread_select = spread_sel[1];
      next_fields.pll_c_spread_select = spread_sel[2];
      next_fields.pll_d_spread_select = spread_sel[3];
      next_fields.pll_a_pair_select = pair_sel[0];
      next_fields.pll_b_pair_select = pair_sel[1];
      next_fields.pll_c_pair_select = pair_sel[2];
      next_fields.pll_d_pair_select = pair_sel[3];
   end

   // Registered so downstream PLL controls never see decode glitches.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fields <= '0;
      end else begin
         fields <= next_fields; // [R7]
      end
   end

endmodule // clock_synth_control_select_map

/* File: design/clk_synth_cfg_pkg.sv */
// Package for the clock synthesizer configuration map: offsets, field
// positions, reset values and the decoded setting-set carrier.
// Assumes a single 100 MHz core clock and a two-wire bus on sda/scl pins.
package clk_synth_cfg_pkg;

   // ==========================================================================
   // Register space
   // ==========================================================================
   localparam int REG_COUNT = 80;
   localparam logic [6:0] GENERIC_CONFIGURATION_GROUP = 7'h00;
   localparam logic [6:0] FIRST_PLL_CONFIGURATION_GROUP = 7'h10;
   localparam logic [6:0] SECOND_PLL_CONFIGURATION_GROUP = 7'h20;
   localparam logic [6:0] THIRD_PLL_CONFIGURATION_GROUP = 7'h30;
   localparam logic [6:0] FOURTH_PLL_CONFIGURATION_GROUP = 7'h40;
   localparam logic [6:0] ID_BYTE_OFFSET = 7'h00;
   localparam logic [6:0] DEV_ADDR_OFFSET = 7'h01;
   localparam logic [6:0] SINGLE_OUT_OFFSET = 7'h04;
   // Within each PLL group: spread bytes at +0..+2, frequency at +3, pair at +5.
   localparam logic [6:0] SPREAD_REL_OFFSET = 7'h00;
   localparam logic [6:0] FREQ_REL_OFFSET = 7'h03;
   localparam logic [6:0] PAIR_REL_OFFSET = 7'h05;
   localparam int SPREAD_BYTES = 3;
   localparam int DEV_ADDR_LSB = 0;
   localparam int DEV_ADDR_MSB = 1;

   // ==========================================================================
   // Command code and bus timing
   // ==========================================================================
   localparam int CMD_BYTE_MODE_BIT = 7;
   localparam int SCL_MAX_KHZ = 400;
   localparam int CORE_CLK_KHZ = 100_000;
   localparam int SCL_MIN_PERIOD_CYCLES = CORE_CLK_KHZ / SCL_MAX_KHZ;

   // ==========================================================================
   // Reset values: set 0 parks outputs off, set 1 enables them.
   // ==========================================================================
   localparam logic [7:0] OUT_SELECT_RESET = 8'h02;
   localparam logic [7:0] PLAIN_RESET = 8'h00;

   typedef struct packed {
      logic [2:0] active_set;
      logic single_output_select;
      logic pll_a_freq_select;
      logic pll_b_freq_select;
      logic pll_c_freq_select;
      logic pll_d_freq_select;
      logic [2:0] pll_a_spread_select;
      logic [2:0] pll_b_spread_select;
      logic [2:0] pll_c_spread_select;
      logic [2:0] pll_d_spread_select;
      logic pll_a_pair_select;
      logic pll_b_pair_select;
      logic pll_c_pair_select;
      logic pll_d_pair_select;
   } set_fields_t;

endpackage

/* File: design/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/10ps
module pin_sync
   import clk_synth_cfg_pkg::*;
#(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   // A bank without a single bit has nothing to carry.
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync WIDTH must be at least one");
   end

   // ==========================================================================
   // Synchroniser chain
   // ==========================================================================
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   // Only stage2 reads meta; the filter looks at stages two and three alone.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
      end else begin
         meta <= pin;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // A bit moves only once two stages agree, which rejects one-cycle glitches.
   assign agree = ~(stage2 ^ stage3);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         level <= RESET_LEVEL;
      end else begin
         level <= (agree & stage3) | (~agree & level);
      end
   end

endmodule // pin_sync

/* File: testbench/ctl_map_chk.sv */
// Concurrent checks on the configuration map's serial pins and decoded fields.
// Assumes one clock domain and an open-drain SDA line resolved outside.
`timescale 1ns/10ps
module ctl_map_chk
   import clk_synth_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic pins_as_control,
   input wire logic ctl_pin_lsb,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire set_fields_t fields
);
   // =========================================================================
   // Assertions
   // =========================================================================
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // Eight settled cycles leave room for the three-stage sync and filter.
   chk_sda_drive_low: assert property (!sda_out)
      else $error("sda_out went high");
   chk_strap_mutes_bus: assert property (pins_as_control[*8] |-> !sda_oe)
      else $error("bus answered while pins act as control pins");
   chk_bus_mode_index: assert property ((!pins_as_control)[*8] |->
      fields.active_set[2:1] == 2'b00) else $error("bus pins leaked into set index");
   chk_lsb_follows: assert property ($stable(ctl_pin_lsb)[*8] |->
      fields.active_set[0] == ctl_pin_lsb) else $error("set index lsb wrong");
   chk_full_index: assert property ((pins_as_control &&
      $stable({scl_in, sda_in, ctl_pin_lsb}))[*8] |->
      fields.active_set == {scl_in, sda_in, ctl_pin_lsb}) else $error("set index wrong");
   chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda drive changed while scl high");
   chk_oe_holds: assert property ($rose(sda_oe) |=> sda_oe[*3])
      else $error("sda drive pulse too short");
   chk_fields_quiet: assert property (($stable(ctl_pin_lsb) &&
      $stable(pins_as_control) && scl_in && sda_in)[*8] |-> $stable(fields))
      else $error("fields moved with pins and bus quiet");
endmodule // ctl_map_chk

bind clock_synth_control_select_map ctl_map_chk u_chk (.core_clk(core_clk), .srst(srst),
   .pins_as_control(pins_as_control), .ctl_pin_lsb(ctl_pin_lsb), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .fields(fields));

/* File: testbench/i2c_master_model.sv */
// Behavioural two-wire bus master driving the map's serial pins.
// Assumes the bench resolves the open-drain SDA line with a pull-up.
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl_drv,
   output logic sda_drv
);
   // =========================================================================
   // Bit timing
   // =========================================================================
   // A 63-clock quarter keeps SCL just under 400 kHz; a quarter below 62 would overrun it.
   int qtr = 63;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic set_pins(input logic c, input logic d);
      @(posedge core_clk);
      scl_drv <= c;
      sda_drv <= d;
   endtask
   task automatic step(input logic c, input logic d);
      set_pins(c, d);
      repeat (qtr) @(posedge core_clk);
   endtask
   // =========================================================================
   // Framing
   // =========================================================================
   // SDA only moves with SCL low, except in start and stop.
   task automatic bus_start();
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic bus_stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic d, output logic s);
      step(1'b0, d);
      step(1'b1, d);
      s = sda_line;
      step(1'b1, d);
      step(1'b0, d);
   endtask
   // Bytes go most significant bit first; a released line reads the pull-up.
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic recv_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(nack, s);
   endtask
endmodule // i2c_master_model

/* File: testbench/tb_clock_synth_control_select_map.sv */
// Self-checking bench for the configuration map and set selection.
// Assumes the bus master model and checker files are compiled alongside.
`timescale 1ns/10ps
module tb_clock_synth_control_select_map
   import clk_synth_cfg_pkg::*;
;
   localparam logic [7:0] TB_ID = 8'hA6; // Arbitrary identity value, low bit clear.
   localparam logic [7:0] ADDR_W = {5'h19, 2'b00, 1'b0};
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic pins_as_control = 1'b0;
   logic ctl_pin_lsb = 1'b0;
   logic scl_drv, sda_drv, sda_line, sda_out, sda_oe;
   set_fields_t fields;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] out_byte = 8'h02;
   logic [7:0] freq_b[4] = '{default: 8'h00};
   logic [7:0] pair_b[4] = '{default: 8'h02};
   logic [7:0] spr_b[4][3] = '{default: 8'h00};

   // =========================================================================
   // Structure
   // =========================================================================
   // The line is low if either party pulls it; otherwise the pull-up wins.
   assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
   always #5 core_clk = ~core_clk;
   i2c_master_model m (.core_clk(core_clk), .sda_line(sda_line), .scl_drv(scl_drv),
      .sda_drv(sda_drv));
   clock_synth_control_select_map #(.ID_BYTE(TB_ID), .BUS_ADDR_HI(5'h19)) uut (
      .core_clk(core_clk), .srst(srst), .pins_as_control(pins_as_control),
      .ctl_pin_lsb(ctl_pin_lsb), .scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .fields(fields));

   // =========================================================================
   // Helpers
   // =========================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Field bit k of each select byte belongs to setting set k.
   function automatic set_fields_t expect_set(input int k);
      return {3'(k), out_byte[k], freq_b[0][k], freq_b[1][k], freq_b[2][k], freq_b[3][k],
         spr_b[0][2][k], spr_b[0][1][k], spr_b[0][0][k], spr_b[1][2][k], spr_b[1][1][k],
         spr_b[1][0][k], spr_b[2][2][k], spr_b[2][1][k], spr_b[2][0][k], spr_b[3][2][k],
         spr_b[3][1][k], spr_b[3][0][k], pair_b[0][k], pair_b[1][k], pair_b[2][k],
         pair_b[3][k]};
   endfunction
   // Offset zero is never written, so identity content is preserved.
   task automatic bus_write(input logic [7:0] cmd, input logic [7:0] d[$],
      output logic [7:0] acks);
      logic a;
      acks = 8'h00;
      m.bus_start();
      m.send_byte(ADDR_W, a);
      acks = {acks[6:0], a};
      m.send_byte(cmd, a);
      acks = {acks[6:0], a};
      foreach (d[i]) begin
         m.send_byte(d[i], a);
         acks = {acks[6:0], a};
      end
      m.bus_stop();
   endtask

   // =========================================================================
   // Scenarios
   // =========================================================================
   task automatic t_reset_sets();
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         ctl_pin_lsb <= k[0];
         repeat (10) @(posedge core_clk);
         check(32'(fields), 32'(expect_set(k)));
      end
   endtask
   task automatic t_id_and_addr();
      logic a;
      logic [7:0] b;
      logic [7:0] b2;
      // Block read of two bytes: identity, then the address byte at reset.
      m.bus_start();
      m.send_byte(ADDR_W, a);
      m.send_byte(8'h00, a);
      m.bus_start();
      m.send_byte(ADDR_W | 8'h01, a);
      m.recv_byte(1'b0, b);
      m.recv_byte(1'b1, b2);
      m.bus_stop();
      check(32'(b), 32'(TB_ID));
      check(32'(b2), 32'h0000_0000);
      m.bus_start();
      m.send_byte({5'h19, 2'b01, 1'b0}, a);
      m.bus_stop();
      check(32'(a), 32'h0000_0000);
   endtask
   task automatic t_writes();
      logic [7:0] acks;
      bus_write(8'h84, '{8'h96, 8'h55}, acks);
      check(32'(acks[3:0]), 32'h0000_000E);
      out_byte = 8'h96;
      bus_write(8'h10, '{8'h0F, 8'h33, 8'h55, 8'hA5, 8'h00, 8'h3C}, acks);
      check(32'(acks), 32'h0000_00FF);
      spr_b[0] = '{8'h0F, 8'h33, 8'h55};
      freq_b[0] = 8'hA5;
      pair_b[0] = 8'h3C;
      bus_write(8'h40, '{8'hF0, 8'hCC, 8'hAA, 8'h5A, 8'h00, 8'hC3}, acks);
      check(32'(acks), 32'h0000_00FF);
      spr_b[3] = '{8'hF0, 8'hCC, 8'hAA};
      freq_b[3] = 8'h5A;
      pair_b[3] = 8'hC3;
      bus_write(8'hA3, '{8'h69}, acks);
      freq_b[1] = 8'h69;
      bus_write(8'hB3, '{8'h1E}, acks);
      freq_b[2] = 8'h1E;
      check(32'(acks[2:0]), 32'h0000_0007);
   endtask
   task automatic t_select_all();
      @(posedge core_clk);
      pins_as_control <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         m.set_pins(k[2], k[1]);
         ctl_pin_lsb <= k[0];
         repeat (10) @(posedge core_clk);
         check(32'(fields), 32'(expect_set(k)));
      end
   endtask

   // =========================================================================
   // Sequence and timeout
   // =========================================================================
   // About 77000 cycles of bus traffic are expected; the ceiling adds margin.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      repeat (8) @(posedge core_clk);
      t_reset_sets();
      t_id_and_addr();
      t_writes();
      t_select_all();
      end_of_test();
   end
endmodule // tb_clock_synth_control_select_map
